// ==== hw/spip_irq_pins.sv ====
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// R1: Port two/four on line a, one/three on b.
// R2: Line high when enabled and condition active.
// R3: Line low on service, disable, master reset.
// R4: Cleared output-enable bit floats the serial line. Master reset drives both serial lines low regardless.
// R5: Parallel line active high, follows acknowledge.
// R6: Parallel enable needs bit 4 and line selection.
// R7: Disabled parallel line is left floating.
// R8: Pin bidirectional only in extended mode, configured.
// R9: Second parallel line behaves identically, chosen by select bit 0.
// R10: All lines change on clock edges only.
module spip_irq_pins
  import spip_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_master_rst,
  input wire logic [3:0] i_ser0_cond,
  input wire logic [3:0] i_ser1_cond,
  input wire logic i_ser0_clear,
  input wire logic i_ser1_clear,
  input wire logic i_ack_n,
  input wire logic i_parallel_irq_a,
  input wire logic i_parallel_irq_b,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_serial_irq_a,
  output logic o_serial_irq_a_oe_n,
  output logic o_serial_irq_b,
  output logic o_serial_irq_b_oe_n,
  output logic o_parallel_irq_a,
  output logic o_parallel_irq_a_oe_n,
  output logic o_parallel_irq_b,
  output logic o_parallel_irq_b_oe_n,
  output logic o_irq
);
  // ****************************************************************
  // Reset release and pin synchronisers
  // ****************************************************************
  logic [1:0] rst_q; // Reset release chain
  logic rst_n; // Synchronised reset used everywhere below
  logic [1:0] mr_q; // Master reset pin sync
  logic [1:0] ack_q; // Acknowledge pin sync
  logic [1:0] pina_q; // Parallel line a input sync
  logic [1:0] pinb_q; // Parallel line b input sync
  logic mr; // Synchronised master reset
  logic ack_lvl; // Synchronised acknowledge level

  // Two stages: asynchronous assert, clocked release
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Pins come from outside, so each passes two flops before use
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mr_q <= 2'h0;
      ack_q <= 2'h3;
      pina_q <= 2'h0;
      pinb_q <= 2'h0;
    end else begin
      mr_q <= {mr_q[0], i_master_rst};
      ack_q <= {ack_q[0], i_ack_n};
      pina_q <= {pina_q[0], i_parallel_irq_a};
      pinb_q <= {pinb_q[0], i_parallel_irq_b};
    end
  end
  assign mr = mr_q[1];
  assign ack_lvl = ack_q[1];

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [6:0] ser0_cfg_q, ser0_cfg_d; // Port 0 enables, output enable, port
  logic [6:0] ser1_cfg_q, ser1_cfg_d; // Port 1 likewise
  logic [4:0] par_ctrl_q, par_ctrl_d; // Parallel control
  logic [3:0] stat_q, stat_d; // Sticky event bits
  logic [3:0] mask_q, mask_d; // Event mask
  logic ack_wb_q, ack_wb_d; // Bus acknowledge
  logic [31:0] rdat_q, rdat_d; // Read data
  logic irq_q, irq_d; // Interrupt output
  logic [3:0] ev; // Event pulses this cycle
  logic wr; // Write strobe, low byte lane
  logic [6:0] pin_stat; // Live pin state for reads

  // Write lands at the edge where the master samples ack; it still holds address and data there
  assign wr = i_wb_cyc & i_wb_stb & i_wb_we & ack_wb_q & i_wb_sel[0];

  // Decode, write and read; set wins over write-one-to-clear
  always_comb begin
    ser0_cfg_d = ser0_cfg_q;
    ser1_cfg_d = ser1_cfg_q;
    par_ctrl_d = par_ctrl_q;
    mask_d = mask_q;
    stat_d = stat_q;
    rdat_d = 32'h0000_0000;
    ack_wb_d = i_wb_cyc & i_wb_stb & !ack_wb_q;
    if (wr) begin
      case (i_wb_adr)
        SPIP_SER0_CFG_OFS: ser0_cfg_d = i_wb_dat[6:0];
        SPIP_SER1_CFG_OFS: ser1_cfg_d = i_wb_dat[6:0];
        SPIP_PAR_CTRL_OFS: par_ctrl_d = i_wb_dat[4:0];
        SPIP_INT_STAT_OFS: stat_d = stat_q & ~i_wb_dat[3:0];
        SPIP_INT_MASK_OFS: mask_d = i_wb_dat[3:0];
        default: ; // Unmapped writes are acknowledged and dropped
      endcase
    end
    stat_d = stat_d | ev;
    if (i_wb_cyc & i_wb_stb & !i_wb_we & !ack_wb_q) begin
      case (i_wb_adr)
        SPIP_SER0_CFG_OFS: rdat_d = {25'h0, ser0_cfg_q};
        SPIP_SER1_CFG_OFS: rdat_d = {25'h0, ser1_cfg_q};
        SPIP_PAR_CTRL_OFS: rdat_d = {27'h0, par_ctrl_q};
        SPIP_PIN_STAT_OFS: rdat_d = {25'h0, pin_stat};
        SPIP_INT_STAT_OFS: rdat_d = {28'h0, stat_q};
        SPIP_INT_MASK_OFS: rdat_d = {28'h0, mask_q};
        default: rdat_d = 32'h0000_0000; // Unmapped reads as zero
      endcase
    end
    // Master reset returns configuration to defaults
    if (mr) begin
      ser0_cfg_d = SPIP_SER_CFG_RST; // [R3]
      ser1_cfg_d = SPIP_SER_CFG_RST; // [R3]
      par_ctrl_d = SPIP_PAR_CTRL_RST;
    end
    irq_d = |(stat_d & mask_d);
  end

  // Registers only
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ser0_cfg_q <= SPIP_SER_CFG_RST;
      ser1_cfg_q <= SPIP_SER_CFG_RST;
      par_ctrl_q <= SPIP_PAR_CTRL_RST;
      stat_q <= SPIP_INT_RST;
      mask_q <= SPIP_INT_RST;
      ack_wb_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end else begin
      ser0_cfg_q <= ser0_cfg_d;
      ser1_cfg_q <= ser1_cfg_d;
      par_ctrl_q <= par_ctrl_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      ack_wb_q <= ack_wb_d;
      rdat_q <= rdat_d;
      irq_q <= irq_d;
    end
  end

  assign o_wb_ack = ack_wb_q;
  assign o_wb_dat = rdat_q;
  assign o_irq = irq_q;

  // ****************************************************************
  // Serial request qualification and routing
  // ****************************************************************
  logic ser0_req; // Port 0 qualified request
  logic ser1_req; // Port 1 qualified request
  logic ser0_oe; // Port 0 output enable
  logic ser1_oe; // Port 1 output enable
  logic ser0_on_a; // Port 0 assigned to two or four
  logic ser1_on_a; // Port 1 assigned to two or four

  assign ser0_oe = ser0_cfg_q[SPIP_SER_OE_BIT];
  assign ser1_oe = ser1_cfg_q[SPIP_SER_OE_BIT];
  // Ports two and four have odd indices
  assign ser0_on_a = ser0_cfg_q[SPIP_SER_PORT_LSB]; // [R1]
  assign ser1_on_a = ser1_cfg_q[SPIP_SER_PORT_LSB]; // [R1]

  spip_ser_qual u_ser0 (
    .i_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_clear(i_ser0_clear | mr),
    .i_ier(ser0_cfg_q[SPIP_SER_IER_LSB +: 4]),
    .i_cond(i_ser0_cond),
    .i_out_en(ser0_oe),
    .o_req(ser0_req)
  );

  spip_ser_qual u_ser1 (
    .i_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_clear(i_ser1_clear | mr),
    .i_ier(ser1_cfg_q[SPIP_SER_IER_LSB +: 4]),
    .i_cond(i_ser1_cond),
    .i_out_en(ser1_oe),
    .o_req(ser1_req)
  );

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  logic sa_q, sa_d, sa_oen_q, sa_oen_d; // Serial line a
  logic sb_q, sb_d, sb_oen_q, sb_oen_d; // Serial line b
  logic pa_q, pa_d, pa_oen_q, pa_oen_d; // Parallel line a
  logic pb_q, pb_d, pb_oen_q, pb_oen_d; // Parallel line b
  logic par_en_a; // Parallel line a enabled
  logic par_en_b; // Parallel line b enabled
  logic ecp_a; // Line a bidirectional
  logic ecp_b; // Line b bidirectional
  logic ser0_prev_q, ser1_prev_q, ack_prev_q, ext_prev_q; // Edge history
  logic ext_lvl; // Input seen on the configured bidirectional line

  assign par_en_a = par_ctrl_q[SPIP_PAR_IEN_BIT] & !par_ctrl_q[SPIP_PAR_SEL_BIT]; // [R6] [R9]
  assign par_en_b = par_ctrl_q[SPIP_PAR_IEN_BIT] & par_ctrl_q[SPIP_PAR_SEL_BIT]; // [R6] [R9]
  assign ecp_a = par_ctrl_q[SPIP_PAR_ECP_BIT] & !par_ctrl_q[SPIP_PAR_SEL_BIT]; // [R8]
  assign ecp_b = par_ctrl_q[SPIP_PAR_ECP_BIT] & par_ctrl_q[SPIP_PAR_SEL_BIT]; // [R8]
  // Only a bidirectional, undriven line is listened to
  assign ext_lvl = (ecp_a & pa_oen_q & pina_q[1]) | (ecp_b & pb_oen_q & pinb_q[1]); // [R8]
  assign pin_stat = {ext_lvl, !ack_lvl, pb_q, pa_q, sb_q, sa_q, irq_q};

  assign ev[SPIP_EV_SER0] = ser0_req & !ser0_prev_q;
  assign ev[SPIP_EV_SER1] = ser1_req & !ser1_prev_q;
  assign ev[SPIP_EV_ACK] = ack_lvl & !ack_prev_q;
  assign ev[SPIP_EV_EXT] = ext_lvl & !ext_prev_q;

  // Next pin values; ports sharing a line are ORed
  always_comb begin
    sa_d = (ser0_req & ser0_on_a) | (ser1_req & ser1_on_a); // [R1] [R2]
    sb_d = (ser0_req & !ser0_on_a) | (ser1_req & !ser1_on_a); // [R1] [R2]
    sa_oen_d = !((ser0_oe & ser0_on_a) | (ser1_oe & ser1_on_a)); // [R4]
    sb_oen_d = !((ser0_oe & !ser0_on_a) | (ser1_oe & !ser1_on_a)); // [R4]
    pa_d = par_en_a & ack_lvl; // [R5]
    pb_d = par_en_b & ack_lvl; // [R5] [R9]
    pa_oen_d = !par_en_a; // [R7]
    pb_oen_d = !par_en_b; // [R7]
    // Master reset drives both serial lines low
    if (mr) begin
      sa_d = 1'b0; // [R3]
      sb_d = 1'b0; // [R3]
      sa_oen_d = 1'b0; // [R3]
      sb_oen_d = 1'b0; // [R3]
    end
  end

  // Every pin leaves a flop, so no line glitches
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sa_q <= 1'b0;
      sb_q <= 1'b0;
      pa_q <= 1'b0;
      pb_q <= 1'b0;
      sa_oen_q <= 1'b1;
      sb_oen_q <= 1'b1;
      pa_oen_q <= 1'b1;
      pb_oen_q <= 1'b1;
      ser0_prev_q <= 1'b0;
      ser1_prev_q <= 1'b0;
      ack_prev_q <= 1'b1; // Matches the idle acknowledge level, so reset shows no false edge
      ext_prev_q <= 1'b0;
    end else begin
      sa_q <= sa_d; // [R10]
      sb_q <= sb_d; // [R10]
      pa_q <= pa_d; // [R10]
      pb_q <= pb_d; // [R10]
      sa_oen_q <= sa_oen_d;
      sb_oen_q <= sb_oen_d;
      pa_oen_q <= pa_oen_d;
      pb_oen_q <= pb_oen_d;
      ser0_prev_q <= ser0_req;
      ser1_prev_q <= ser1_req;
      ack_prev_q <= ack_lvl;
      ext_prev_q <= ext_lvl;
    end
  end

  assign o_serial_irq_a = sa_q;
  assign o_serial_irq_b = sb_q;
  assign o_serial_irq_a_oe_n = sa_oen_q;
  assign o_serial_irq_b_oe_n = sb_oen_q;
  assign o_parallel_irq_a = pa_q;
  assign o_parallel_irq_b = pb_q;
  assign o_parallel_irq_a_oe_n = pa_oen_q;
  assign o_parallel_irq_b_oe_n = pb_oen_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n);

  a_ser_route_a: assert property ((!mr && ser0_req && ser0_on_a) |=> o_serial_irq_a) // [R1]
    else $error("port on two or four not on line a");
  a_ser_route_b: assert property ((!mr && ser1_req && !ser1_on_a) |=> o_serial_irq_b) // [R1]
    else $error("port on one or three not on line b");
  a_ser_float: assert property ((!mr && !ser0_oe && !ser1_oe) |=> (o_serial_irq_a_oe_n && o_serial_irq_b_oe_n)) // [R4]
    else $error("serial line driven with output enable clear");
  a_mr_low: assert property (mr |=> (!o_serial_irq_a && !o_serial_irq_b)) // [R3]
    else $error("serial line high during master reset");
  a_par_follow: assert property (par_en_a |=> (o_parallel_irq_a == $past(ack_lvl))) // [R5]
    else $error("parallel line a not following acknowledge");
  a_par_float: assert property (!par_en_b |=> (o_parallel_irq_b_oe_n && !o_parallel_irq_b)) // [R7]
    else $error("parallel line b driven while disabled");
  a_par_enable: assert property ((par_ctrl_q[SPIP_PAR_IEN_BIT] && !par_ctrl_q[SPIP_PAR_SEL_BIT])
    |=> !o_parallel_irq_a_oe_n) // [R6]
    else $error("parallel line a not enabled by bit 4");
  a_ext_only_ecp: assert property (!par_ctrl_q[SPIP_PAR_ECP_BIT] |-> !ext_lvl) // [R8]
    else $error("parallel pin read outside extended mode");
  a_one_change: assert property (!mr |=> // [R10]
    (o_serial_irq_a == $past((ser0_req && ser0_on_a) || (ser1_req && ser1_on_a))))
    else $error("serial line a not a registered copy of its requests");
  a_irq_level: assert property ((|(stat_q & mask_q)) |-> o_irq) // [R2]
    else $error("interrupt output low with unmasked status");
  a_wb_ack: assert property ((i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus acknowledge not one cycle");
endmodule : spip_irq_pins

// ==== hw/spip_pkg.sv ====
// ****************************************************************
// Shared constants for the interrupt pin block
// ****************************************************************
package spip_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] SPIP_SER0_CFG_OFS = 8'h00;
  localparam logic [7:0] SPIP_SER1_CFG_OFS = 8'h04;
  localparam logic [7:0] SPIP_PAR_CTRL_OFS = 8'h08;
  localparam logic [7:0] SPIP_PIN_STAT_OFS = 8'h0C;
  localparam logic [7:0] SPIP_INT_STAT_OFS = 8'h10;
  localparam logic [7:0] SPIP_INT_MASK_OFS = 8'h14;

  // Serial configuration fields
  localparam int SPIP_SER_IER_LSB = 0;  // Four enable bits of serial_int_enable_reg
  localparam int SPIP_SER_OE_BIT = 4;   // modem_ctl_out_enable
  localparam int SPIP_SER_PORT_LSB = 5; // Logical port, 0..3 = one..four

  // Parallel control fields
  localparam int SPIP_PAR_SEL_BIT = 0;  // 0: parallel_irq_a, 1: parallel_irq_b
  localparam int SPIP_PAR_ECP_BIT = 1;  // Extended-capabilities mode
  localparam int SPIP_PAR_IEN_BIT = 4;  // Interrupt enable, control bit 4

  // Interrupt status bit positions
  localparam int SPIP_EV_SER0 = 0;
  localparam int SPIP_EV_SER1 = 1;
  localparam int SPIP_EV_ACK = 2;
  localparam int SPIP_EV_EXT = 3;

  // Reset values
  localparam logic [6:0] SPIP_SER_CFG_RST = 7'h00;
  localparam logic [4:0] SPIP_PAR_CTRL_RST = 5'h00;
  localparam logic [3:0] SPIP_INT_RST = 4'h0;
endpackage : spip_pkg

// ==== hw/spip_ser_qual.sv ====
`timescale 1ns/1ps
// ****************************************************************
// One serial port's interrupt request qualifier
// ****************************************************************
module spip_ser_qual
  import spip_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic [3:0] i_ier,
  input wire logic [3:0] i_cond,
  input wire logic i_out_en,
  output logic o_req
);
  logic req_d; // Next request level
  logic req_q; // Registered request level

  // Request is live while an enabled condition is active; it falls as soon
  // as the service routine clears the source or software disables it.
  always_comb begin
    req_d = i_out_en & (|(i_ier & i_cond)); // [R2] [R3]
    if (i_clear) begin
      req_d = 1'b0; // [R3]
    end
  end

  // Register only, so the line never glitches
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_q <= 1'b0;
    end else begin
      req_q <= req_d; // [R10]
    end
  end

  assign o_req = req_q;

  a_req_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_clear && i_out_en && (|(i_ier & i_cond))) |=> o_req) // [R2]
    else $error("serial request not raised for enabled condition");
  a_req_drops: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_clear || (i_ier & i_cond) == 4'h0) |=> !o_req) // [R3]
    else $error("serial request stayed high without source");
endmodule : spip_ser_qual

// ==== verif/spip_host_model.sv ====
`timescale 1ns/1ps
// ********************************
// Host side of the interrupt lines
// ********************************
module spip_host_model (
  input wire logic [3:0] i_line, // Block pin values: ser a, ser b, par a, par b
  input wire logic [3:0] i_oe_n, // Low while the block drives a line
  input wire logic [1:0] i_drv_en, // Host drives a parallel line
  input wire logic [1:0] i_drv_val, // Level the host drives
  output logic [3:0] o_wire // Resolved line levels
);
  logic [3:0] host_en; // Host enable per line
  logic [3:0] host_val; // Host level per line
  assign host_en = {i_drv_en, 2'b00};
  assign host_val = {i_drv_val, 2'b00};
  // Lines carry host pull-downs, so a released line reads low, never its last level
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (!i_oe_n[k] && host_en[k]) begin // Both drive: contention shows as unknown
        o_wire[k] = 1'bx;
      end else if (!i_oe_n[k]) begin // Block drives
        o_wire[k] = i_line[k];
      end else if (host_en[k]) begin // Host drives
        o_wire[k] = host_val[k];
      end else begin // Pull-down
        o_wire[k] = 1'b0;
      end
    end
  end
endmodule : spip_host_model

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
  import spip_pkg::*;
;
  // ********************************
  // Stimulus and wiring
  // ********************************
  logic clk = 1'b0; // 100 MHz clock
  logic arst_n = 1'b0; // Reset held at start
  logic mrst = 1'b0; // Master reset pin
  logic [3:0] c0 = 4'h0; // Serial conditions
  logic [3:0] c1 = 4'h0;
  logic clr0 = 1'b0; // Service done
  logic clr1 = 1'b0;
  logic ack_n = 1'b1; // Printer acknowledge
  logic cyc = 1'b0; // Bus request
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [1:0] drv_en = 2'h0; // Host drive of parallel lines
  logic [1:0] drv_val = 2'h0;
  logic [31:0] rdat;
  logic wack;
  logic irq;
  logic [3:0] line;
  logic [3:0] oe_n;
  logic [3:0] wire_lvl;
  logic [8:0] pins; // Wires 0..3, oe_n 4..7, irq 8
  int failures = 0;
  int n_checks = 0;
  assign pins = {irq, oe_n, wire_lvl};
  always #5 clk = ~clk;
  spip_irq_pins dut (
    .i_sys_clk(clk), .i_arst_n(arst_n), .i_master_rst(mrst), .i_ser0_cond(c0), .i_ser1_cond(c1),
    .i_ser0_clear(clr0), .i_ser1_clear(clr1), .i_ack_n(ack_n),
    .i_parallel_irq_a(wire_lvl[2]), .i_parallel_irq_b(wire_lvl[3]),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(wack), .o_serial_irq_a(line[0]), .o_serial_irq_a_oe_n(oe_n[0]),
    .o_serial_irq_b(line[1]), .o_serial_irq_b_oe_n(oe_n[1]), .o_parallel_irq_a(line[2]),
    .o_parallel_irq_a_oe_n(oe_n[2]), .o_parallel_irq_b(line[3]), .o_parallel_irq_b_oe_n(oe_n[3]), .o_irq(irq));
  spip_host_model host (.i_line(line), .i_oe_n(oe_n), .i_drv_en(drv_en), .i_drv_val(drv_val), .o_wire(wire_lvl));
  // ********************************
  // Check and bus tasks
  // ********************************
  task automatic summarize();
    $display("Checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // Pin levels settle a few edges after their cause, so wait under a bound
  task automatic wait_pin(input int k, input logic e);
    for (int n = 0; n < 12 && pins[k] !== e; n++) begin
      @(posedge clk);
    end
    chk(32'(pins[k]), 32'(e));
    if (pins[k] !== e) begin // Bound spent
      summarize();
    end
  endtask : wait_pin
  // One classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (wack !== 1'b1) begin // No answer
      failures++;
      summarize();
    end
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  // Read, tried up to t times while a synchronised value travels
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input int t = 1);
    logic [31:0] q;
    for (int n = 0; n < t; n++) begin
      wb(1'b0, a, 32'h0, q);
      if ((q & m) === (e & m)) break;
    end
    chk(q & m, e & m);
  endtask : rd
  // ********************************
  // Scenarios
  // ********************************
  task automatic s_regs();
    rd(SPIP_SER0_CFG_OFS, 32'h0, 32'hFFFFFFFF);
    rd(SPIP_PAR_CTRL_OFS, 32'h0, 32'hFFFFFFFF);
    rd(SPIP_INT_MASK_OFS, 32'h0, 32'hFFFFFFFF);
    rd(SPIP_INT_STAT_OFS, 32'h0, 32'hFFFFFFFF); // No event may be latched by reset release
    wr(8'h18, 32'hFF); // Unmapped place drops writes
    rd(8'h18, 32'h0, 32'hFFFFFFFF);
  endtask : s_regs
  // Each logical port on its line, each condition through its own enable
  task automatic s_route();
    for (int p = 0; p < 4; p++) begin
      wr(SPIP_SER0_CFG_OFS, 32'(p << 5 | 16 | 1 << p));
      @(posedge clk);
      c0 <= 4'(1 << p);
      wait_pin(p % 2 == 1 ? 0 : 1, 1'b1);
      wait_pin(p % 2 == 1 ? 4 : 5, 1'b0);
      wait_pin(p % 2 == 1 ? 1 : 0, 1'b0);
      wr(SPIP_SER0_CFG_OFS, 32'(p << 5 | 16 | (15 ^ 1 << p)));
      wait_pin(p % 2 == 1 ? 0 : 1, 1'b0);
      @(posedge clk);
      c0 <= 4'h0;
    end
    wr(SPIP_SER0_CFG_OFS, 32'h2F); // Enables set but output enable cleared
    @(posedge clk);
    c0 <= 4'hF;
    wait_pin(4, 1'b1);
    wait_pin(0, 1'b0);
    @(posedge clk);
    c0 <= 4'h0;
  endtask : s_route
  task automatic s_clear();
    wr(SPIP_SER1_CFG_OFS, 32'h1F); // Port one on line b
    @(posedge clk);
    c1 <= 4'h2;
    wait_pin(1, 1'b1);
    @(posedge clk);
    c1 <= 4'h0;
    clr1 <= 1'b1;
    @(posedge clk);
    clr1 <= 1'b0;
    wait_pin(1, 1'b0);
    @(posedge clk);
    c1 <= 4'h2;
    wait_pin(1, 1'b1);
    @(posedge clk);
    mrst <= 1'b1;
    wait_pin(1, 1'b0);
    wait_pin(5, 1'b0);
    @(posedge clk);
    mrst <= 1'b0;
    wait_pin(5, 1'b1); // Config cleared, line released
    rd(SPIP_SER1_CFG_OFS, 32'h0, 32'hFF);
    @(posedge clk);
    c1 <= 4'h0;
  endtask : s_clear
  // Sticky status, mask and the summary output
  task automatic s_irq();
    wr(SPIP_SER0_CFG_OFS, 32'h3F);
    wr(SPIP_INT_MASK_OFS, 32'h0);
    wr(SPIP_INT_STAT_OFS, 32'hF);
    @(posedge clk);
    c0 <= 4'h1;
    wait_pin(0, 1'b1);
    rd(SPIP_INT_STAT_OFS, 32'h1, 32'h1, 4);
    wait_pin(8, 1'b0);
    wr(SPIP_INT_MASK_OFS, 32'h1);
    wait_pin(8, 1'b1);
    @(posedge clk);
    c0 <= 4'h0;
    wait_pin(0, 1'b0);
    wr(SPIP_INT_STAT_OFS, 32'h1);
    wait_pin(8, 1'b0);
    rd(SPIP_INT_STAT_OFS, 32'h0, 32'h1);
  endtask : s_irq
  task automatic s_par();
    for (int s = 0; s < 2; s++) begin
      wr(SPIP_PAR_CTRL_OFS, 32'(16 | s));
      wait_pin(6 + s, 1'b0);
      wait_pin(7 - s, 1'b1);
      @(posedge clk);
      ack_n <= 1'b0;
      wait_pin(2 + s, 1'b0);
      @(posedge clk);
      ack_n <= 1'b1;
      wait_pin(2 + s, 1'b1);
      wr(SPIP_PAR_CTRL_OFS, 32'(s)); // Enable bit cleared
      wait_pin(6 + s, 1'b1);
    end
  endtask : s_par
  // Line a configured in extended mode, not driven: host level is read back
  task automatic s_ext();
    wr(SPIP_PAR_CTRL_OFS, 32'h02);
    @(posedge clk);
    drv_en <= 2'b01;
    drv_val <= 2'b01;
    wait_pin(2, 1'b1);
    rd(SPIP_PIN_STAT_OFS, 32'h40, 32'h40, 8);
    rd(SPIP_INT_STAT_OFS, 32'h8, 32'h8, 8);
    wait_pin(6, 1'b1);
    wr(SPIP_PAR_CTRL_OFS, 32'h00);
    rd(SPIP_PIN_STAT_OFS, 32'h0, 32'h40, 8);
    @(posedge clk);
    drv_en <= 2'b00;
  endtask : s_ext
  // ********************************
  // Main sequence
  // ********************************
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    s_regs();
    s_route();
    s_clear();
    s_irq();
    s_par();
    s_ext();
    summarize();
  end
endmodule : tb_top
